// File: hw/fpi_fifth_port.sv
// Fifth-port pin logic: PHY-only transceiver port and switch-side MII/SNI port.
`timescale 1ns/100ps
`default_nettype none
module fpi_fifth_port (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] swport_role_strap,
    input  wire logic       phyport_tx_enable,
    input  wire logic       phyport_tx_error,
    input  wire logic [3:0] phyport_tx_nibble,
    output logic            phyport_tx_clock,
    output logic            phyport_rx_clock,
    output logic            phyport_rx_valid,
    output logic            phyport_rx_error,
    output logic [3:0]      phyport_rx_nibble,
    output logic            phyport_collision,
    output logic            phyport_carrier_sense,
    input  wire logic       mdc,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe,
    output logic            iphy_tx_valid,
    output logic            iphy_tx_error,
    output logic [3:0]      iphy_tx_nibble,
    input  wire logic       iphy_rx_valid,
    input  wire logic       iphy_rx_error,
    input  wire logic [3:0] iphy_rx_nibble,
    input  wire logic       iphy_collision,
    input  wire logic       iphy_carrier,
    output logic            mgmt_clock,
    output logic            mgmt_data_in,
    input  wire logic       mgmt_data_out,
    input  wire logic       mgmt_data_oe,
    input  wire logic       swport_tx_enable,
    input  wire logic       swport_tx_error,
    input  wire logic [3:0] swport_tx_data,
    output logic            swport_rx_valid,
    output logic [3:0]      swport_rx_data,
    input  wire logic       swport_tx_clock_in,
    output logic            swport_tx_clock_out,
    output logic            swport_tx_clock_oe,
    input  wire logic       swport_rx_clock_in,
    output logic            swport_rx_clock_out,
    output logic            swport_rx_clock_oe,
    input  wire logic       swport_collision_in,
    output logic            swport_collision_out,
    output logic            swport_collision_oe,
    input  wire logic       swport_carrier_sense_in,
    output logic            swport_carrier_sense_out,
    output logic            swport_carrier_sense_oe,
    input  wire logic       mac_tx_valid,
    input  wire logic [3:0] mac_tx_nibble,
    output logic            mac_tx_take,
    output logic            mac_rx_valid,
    output logic [3:0]      mac_rx_nibble,
    output logic            mac_rx_error,
    input  wire logic       core_collision,
    input  wire logic       core_carrier,
    output logic            mac_collision,
    output logic            mac_carrier
);

    localparam int DIV_W = (fpi_pkg::LINK_HALF_CYC > 1) ? $clog2(fpi_pkg::LINK_HALF_CYC) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(fpi_pkg::LINK_HALF_CYC - 1);
    localparam logic [6:0] IPG_BITS = 7'(fpi_pkg::IPG_BIT_TIMES);

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers, role capture and link clock divider.

    logic [fpi_pkg::SYNC_W-1:0] async_w;
    logic [fpi_pkg::SYNC_W-1:0] s1_ff;
    logic [fpi_pkg::SYNC_W-1:0] s2_ff;
    logic [1:0]                 clk_s3_ff;
    fpi_pkg::fpi_role_t         role_ff;
    logic                       role_ok_ff;
    logic [DIV_W-1:0]           div_ff;
    logic                       lclk_ff;

    assign async_w = {swport_role_strap, swport_carrier_sense_in, swport_collision_in,
                      swport_rx_clock_in, swport_tx_clock_in, swport_tx_data,
                      swport_tx_error, swport_tx_enable, mdio_in, mdc,
                      phyport_tx_nibble, phyport_tx_error, phyport_tx_enable};

    always_ff @(posedge clk) begin
        s1_ff     <= async_w;
        s2_ff     <= s1_ff;
        clk_s3_ff <= s2_ff[15:14];
    end

    // [R13] role held constant
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            role_ff    <= fpi_pkg::FPI_ROLE_PHY;
            role_ok_ff <= 1'b0;
        end else if (!role_ok_ff) begin
            role_ff    <= fpi_pkg::fpi_decode_role(s2_ff[19:18]);
            role_ok_ff <= 1'b1;
        end
    end

    // [R3] [R9] link clock divider
    wire tick_w   = (div_ff == DIV_LAST);
    wire own_fall = tick_w & lclk_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_ff  <= '0;
            lclk_ff <= 1'b0;
        end else begin
            div_ff  <= tick_w ? '0 : div_ff + DIV_W'(1);
            lclk_ff <= tick_w ? ~lclk_ff : lclk_ff;
        end
    end

    wire is_mac = role_ok_ff & (role_ff == fpi_pkg::FPI_ROLE_MAC);
    wire is_sni = role_ok_ff & (role_ff == fpi_pkg::FPI_ROLE_SNI);
    wire is_phy = role_ok_ff & (role_ff == fpi_pkg::FPI_ROLE_PHY);

    // [R8] crossed clocks in MAC role
    wire txc_rise     = s2_ff[14] & ~clk_s3_ff[0];
    wire rxc_rise     = s2_ff[15] & ~clk_s3_ff[1];
    wire sample_beat  = role_ok_ff & (is_mac ? txc_rise : own_fall);
    wire launch_beat  = role_ok_ff & (is_mac ? rxc_rise : own_fall);
    wire [6:0] beat_bits = is_sni ? 7'(fpi_pkg::SNI_BEAT_BITS) : 7'(fpi_pkg::MII_BEAT_BITS);
    wire carrier_w    = is_mac ? s2_ff[17] : core_carrier;
    wire coll_w       = is_mac ? s2_ff[16] : core_collision;

    ////////////////////////////////////////////////////////////////////////////////
    // Fifth transceiver port, always in PHY role.

    logic       ph_txv_ff, ph_txe_ff, ph_rxv_ff, ph_rxe_ff, ph_col_ff, ph_crs_ff;
    logic [3:0] ph_txd_ff, ph_rxd_ff;
    logic       mgc_ff, mgd_ff, mdo_ff, mdoe_ff;

    // [R1] [R7] PHY-role beat handling
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {ph_txv_ff, ph_txe_ff, ph_rxv_ff, ph_rxe_ff, ph_col_ff, ph_crs_ff} <= '0;
            {ph_txd_ff, ph_rxd_ff, mgc_ff, mgd_ff, mdo_ff, mdoe_ff} <= '0;
        end else begin
            ph_txv_ff <= own_fall & s2_ff[0];
            ph_txe_ff <= own_fall & s2_ff[0] & s2_ff[1];
            ph_txd_ff <= own_fall ? s2_ff[5:2] : ph_txd_ff;
            ph_rxv_ff <= own_fall ? iphy_rx_valid : ph_rxv_ff;
            ph_rxe_ff <= own_fall ? iphy_rx_error : ph_rxe_ff;
            ph_rxd_ff <= own_fall ? iphy_rx_nibble : ph_rxd_ff;
            ph_col_ff <= iphy_collision;
            ph_crs_ff <= iphy_carrier;
            mgc_ff    <= s2_ff[6];
            mgd_ff    <= s2_ff[7];
            mdo_ff    <= mgmt_data_out;
            mdoe_ff   <= mgmt_data_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Switch-side transmit toward the link, with inter-frame gap.

    logic       tx_act_ff, take_ff, coll_seen_ff, sw_rxv_ff;
    logic [3:0] tx_sh_ff, sw_rxd_ff;
    logic [1:0] tx_cnt_ff;
    logic [6:0] gap_ff;

    wire       need_new   = ~tx_act_ff | (tx_cnt_ff == 2'h0);
    wire       gap_ok     = gap_ff >= IPG_BITS;
    wire       take_w     = launch_beat & need_new & mac_tx_valid & (tx_act_ff | gap_ok);
    wire       nxt_tx_act = (launch_beat & need_new) ? take_w : tx_act_ff;
    wire       shift_w    = launch_beat & tx_act_ff & ~need_new;
    wire [3:0] nxt_tx_sh  = take_w ? mac_tx_nibble : (shift_w ? {1'b0, tx_sh_ff[3:1]} : tx_sh_ff);
    wire [1:0] nxt_tx_cnt = take_w ? (is_sni ? 2'h3 : 2'h0) :
                            (shift_w ? tx_cnt_ff - 2'h1 : tx_cnt_ff);
    // [R10] [R11] serial carrier and bit 0
    wire       nxt_sw_rxv = is_sni ? (nxt_tx_act | core_carrier) :
                            (launch_beat ? nxt_tx_act : sw_rxv_ff);
    wire [3:0] nxt_sw_rxd = ~launch_beat ? sw_rxd_ff :
                            (is_sni ? {3'h0, nxt_tx_sh[0]} : nxt_tx_sh);
    // [R12] gap restart rule
    wire       gap_hold   = nxt_tx_act | (coll_seen_ff & carrier_w);
    wire [6:0] nxt_gap    = gap_hold ? 7'h0 :
                            ((launch_beat & ~gap_ok) ? gap_ff + beat_bits : gap_ff);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {tx_act_ff, take_ff, coll_seen_ff, sw_rxv_ff} <= '0;
            {tx_sh_ff, sw_rxd_ff, tx_cnt_ff} <= '0;
            gap_ff <= IPG_BITS;
        end else begin
            tx_act_ff    <= nxt_tx_act;
            take_ff      <= take_w;
            tx_sh_ff     <= nxt_tx_sh;
            tx_cnt_ff    <= nxt_tx_cnt;
            sw_rxv_ff    <= nxt_sw_rxv;
            sw_rxd_ff    <= nxt_sw_rxd;
            gap_ff       <= nxt_gap;
            coll_seen_ff <= (tx_act_ff & coll_w) | (coll_seen_ff & (carrier_w | tx_act_ff));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Switch-side receive from the link, and pin directions.

    logic       rxv_ff, rxe_ff, clk_oe_ff, col_oe_ff, crs_oe_ff, col_o_ff, crs_o_ff;
    logic       mcol_ff, mcrs_ff;
    logic [3:0] rx_sh_ff, rx_nib_ff;
    logic [1:0] rx_cnt_ff;

    // [R4] [R9] nibble or bit assembly
    wire [3:0] rx_shin = {s2_ff[10], rx_sh_ff[3:1]};
    wire       rx_bit  = sample_beat & s2_ff[8];
    wire       rx_fire = rx_bit & (~is_sni | (rx_cnt_ff == 2'h3));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {rxv_ff, rxe_ff, rx_sh_ff, rx_nib_ff, rx_cnt_ff} <= '0;
            {clk_oe_ff, col_oe_ff, crs_oe_ff, col_o_ff, crs_o_ff, mcol_ff, mcrs_ff} <= '0;
        end else begin
            rxv_ff    <= rx_fire;
            rxe_ff    <= rx_fire & ~is_sni & s2_ff[9];
            rx_nib_ff <= rx_fire ? (is_sni ? rx_shin : s2_ff[13:10]) : rx_nib_ff;
            rx_sh_ff  <= rx_bit ? rx_shin : rx_sh_ff;
            rx_cnt_ff <= rx_bit ? rx_cnt_ff + 2'h1 : (sample_beat ? 2'h0 : rx_cnt_ff);
            // [R2] role-driven pin direction
            clk_oe_ff <= is_phy | is_sni;
            col_oe_ff <= is_phy | is_sni;
            crs_oe_ff <= is_phy;
            col_o_ff  <= core_collision;
            crs_o_ff  <= core_carrier;
            mcol_ff   <= coll_w;
            mcrs_ff   <= carrier_w;
        end
    end

    assign phyport_tx_clock         = lclk_ff;
    assign phyport_rx_clock         = lclk_ff;
    assign phyport_rx_valid         = ph_rxv_ff;
    assign phyport_rx_error         = ph_rxe_ff;
    assign phyport_rx_nibble        = ph_rxd_ff;
    assign phyport_collision        = ph_col_ff;
    assign phyport_carrier_sense    = ph_crs_ff;
    assign mdio_out                 = mdo_ff;
    assign mdio_oe                  = mdoe_ff;
    assign iphy_tx_valid            = ph_txv_ff;
    assign iphy_tx_error            = ph_txe_ff;
    assign iphy_tx_nibble           = ph_txd_ff;
    assign mgmt_clock               = mgc_ff;
    assign mgmt_data_in             = mgd_ff;
    assign swport_rx_valid          = sw_rxv_ff;
    assign swport_rx_data           = sw_rxd_ff;
    assign swport_tx_clock_out      = lclk_ff;
    assign swport_rx_clock_out      = lclk_ff;
    assign swport_tx_clock_oe       = clk_oe_ff;
    assign swport_rx_clock_oe       = clk_oe_ff;
    assign swport_collision_out     = col_o_ff;
    assign swport_collision_oe      = col_oe_ff;
    assign swport_carrier_sense_out = crs_o_ff;
    assign swport_carrier_sense_oe  = crs_oe_ff;
    assign mac_tx_take              = take_ff;
    assign mac_rx_valid             = rxv_ff;
    assign mac_rx_nibble            = rx_nib_ff;
    assign mac_rx_error             = rxe_ff;
    assign mac_collision            = mcol_ff;
    assign mac_carrier              = mcrs_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence clk_high_phase;
        phyport_tx_clock [*4] ##1 !phyport_tx_clock;
    endsequence

    role_hold_a: assert property (role_ok_ff && $past(role_ok_ff) |-> $stable(role_ff)) // [R13]
        else $error("switch port role changed after capture");
    link_clk_rate_a: assert property ($rose(phyport_tx_clock) |-> clk_high_phase) // [R3]
        else $error("link clock high phase not four cycles");
    inter_gap_a: assert property ($rose(tx_act_ff) |-> $past(gap_ff) >= IPG_BITS) // [R12]
        else $error("frame started before the inter-frame gap");
    sni_bit0_a: assert property (is_sni && $past(is_sni) |-> swport_rx_data[3:1] == 3'h0) // [R10]
        else $error("serial mode drove upper data bits");
    sni_carrier_a: assert property (is_sni && $past(is_sni) |-> // [R11]
        swport_rx_valid == (tx_act_ff || $past(core_carrier)))
        else $error("serial carrier sense not on receive-valid pin");
    sni_take_a: assert property (is_sni && mac_tx_take |=> !mac_tx_take [*8]) // [R9]
        else $error("serial nibble taken too early");
    mac_clk_dir_a: assert property ($past(is_mac) |-> !swport_tx_clock_oe && !swport_rx_clock_oe) // [R8]
        else $error("clock driven in MAC role");
    phy_clk_dir_a: assert property ($past(is_phy) |-> swport_rx_clock_oe && swport_carrier_sense_oe) // [R2]
        else $error("clock or carrier not driven in PHY role");
    phy_nibble_a: assert property (iphy_tx_valid |-> iphy_tx_nibble == $past(phyport_tx_nibble, 3)) // [R7]
        else $error("fifth port nibble not passed through");
    mii_rx_a: assert property (mac_rx_valid && !is_sni |-> mac_rx_nibble == $past(s2_ff[13:10])) // [R4]
        else $error("switch port nibble mismatch");

endmodule // fpi_fifth_port
`default_nettype wire

// File: hw/fpi_pkg.sv
// Constants, role codes and helpers for the fifth-port media interface logic.
// Notes on behaviour
// [R1] The fifth transceiver port always acts as a PHY toward an external MAC.
// [R2] The switch-side port works in MAC role or PHY role, chosen by strap.
// [R3] Media independent ports move four bits per clock; clocks run at quarter bit rate.
// [R4] Transmit nibbles qualified by enable and error; receive by valid, error, carrier, collision.
// [R5] In PHY role no receive-error pin exists; the partner holds its input low.
// [R6] In MAC role no transmit-error pin exists; the transceiver holds its input low.
// [R7] Fifth port takes enable, error, nibble; drives clocks, receive lines, collision, carrier, management.
// [R8] MAC role crosses pins: our transmit appears on receive pins and vice versa.
// [R9] Serial mode moves one bit per clock; clocks run at the bit rate.
// [R10] Serial mode uses data bit 0; carrier on receive-valid pin, collision on its pin.
// [R11] Serial transmit qualified by enable; receive has valid; collision in half duplex.
// [R12] Keep 96 bit times between frames; after collision count from carrier sense drop.
// [R13] Switch-side role is sampled once after reset and then held constant.
package fpi_pkg;

    localparam int CLK_PERIOD_NS  = 25;
    localparam int LINK_PERIOD_NS = 200;
    localparam int LINK_HALF_CYC  = ((LINK_PERIOD_NS / 2) / CLK_PERIOD_NS < 1) ? 1 :
                                    (LINK_PERIOD_NS / 2) / CLK_PERIOD_NS;
    localparam int IPG_BIT_TIMES  = 96;
    localparam int MII_BEAT_BITS  = 4;
    localparam int SNI_BEAT_BITS  = 1;
    localparam int SYNC_W         = 20;

    localparam logic [1:0] STRAP_PHY = 2'h0;
    localparam logic [1:0] STRAP_MAC = 2'h1;
    localparam logic [1:0] STRAP_SNI = 2'h2;

    typedef enum logic [1:0] {
        FPI_ROLE_PHY,
        FPI_ROLE_MAC,
        FPI_ROLE_SNI
    } fpi_role_t;

    // Unknown strap codes fall back to the PHY role.
    function automatic fpi_role_t fpi_decode_role(input logic [1:0] strap);
        fpi_role_t r;
        r = FPI_ROLE_PHY;
        if (strap == STRAP_MAC) begin
            r = FPI_ROLE_MAC;
        end else if (strap == STRAP_SNI) begin
            r = FPI_ROLE_SNI;
        end
        return r;
    endfunction

endpackage

// File: tb/fpi_link_partner.sv
// Far-side model on the switch-side port: external MAC, PHY or serial controller.
`timescale 1ns/100ps
`default_nettype none
module fpi_link_partner (
    input  wire logic       mac_role,
    input  wire logic       sni_role,
    input  wire logic       own_clk,
    input  wire logic       link_on,
    input  wire logic       send,
    input  wire logic [3:0] base,
    input  wire logic [3:0] len,
    input  wire logic [3:0] err_at,
    output logic            tx_clk,
    output logic            rx_clk,
    output logic            tx_en,
    output logic            tx_err,
    output logic [3:0]      tx_dat,
    output logic            busy
);
    logic [3:0] idx;
    logic [1:0] bitn;
    logic [3:0] nib;
    wire        lclk = mac_role ? tx_clk : own_clk;
    initial begin
        {tx_clk, rx_clk, tx_en, tx_err, tx_dat, busy, idx, bitn} = '0;
    end
    // The far clocks run only in MAC role while the link is on, in a phase of their own.
    always #100 if (mac_role && link_on) tx_clk = ~tx_clk;
    initial #37 forever #100 if (mac_role && link_on) rx_clk = ~rx_clk;
    // Nibble or bit per beat, LSB first, framed by enable.
    always @(posedge lclk) begin
        #2;
        if (!busy && send) begin
            busy = 1'b1;
            idx  = 4'h0;
            bitn = 2'h0;
        end
        nib   = base + idx * 4'h3;
        tx_en = busy;
        // The error line is held low unless a scenario asks for it.
        tx_err = busy && !sni_role && idx == err_at;
        tx_dat = busy ? (sni_role ? {~tx_dat[3:1], nib[bitn]} : nib) : ~tx_dat;
        if (busy) begin
            bitn = sni_role ? bitn + 2'h1 : 2'h0;
            if (bitn == 2'h0) idx = idx + 4'h1;
            if (idx == len) busy = 1'b0;
        end
    end
endmodule // fpi_link_partner
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the fifth-port pin logic in all strap roles.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic       clk, rst_n, phyport_tx_enable, phyport_tx_error, mdc, mdio_in;
    logic       iphy_rx_valid, iphy_rx_error, iphy_collision, iphy_carrier;
    logic       mgmt_data_out, mgmt_data_oe, swport_tx_enable, swport_tx_error;
    logic       swport_tx_clock_in, swport_rx_clock_in, swport_collision_in;
    logic       swport_carrier_sense_in, mac_tx_valid, core_collision, core_carrier;
    logic       phyport_tx_clock, phyport_rx_clock, phyport_rx_valid, phyport_rx_error;
    logic       phyport_collision, phyport_carrier_sense, mdio_out, mdio_oe;
    logic       iphy_tx_valid, iphy_tx_error, mgmt_clock, mgmt_data_in, swport_rx_valid;
    logic       swport_tx_clock_out, swport_tx_clock_oe, swport_rx_clock_out;
    logic       swport_rx_clock_oe, swport_collision_out, swport_collision_oe;
    logic       swport_carrier_sense_out, swport_carrier_sense_oe, mac_tx_take;
    logic       mac_rx_valid, mac_rx_error, mac_collision, mac_carrier;
    logic       mac_role, sni_role, link_on, send, p_busy;
    logic [1:0] swport_role_strap;
    logic [3:0] phyport_tx_nibble, iphy_rx_nibble, swport_tx_data, mac_tx_nibble;
    logic [3:0] phyport_rx_nibble, iphy_tx_nibble, swport_rx_data, mac_rx_nibble;
    logic [3:0] base, len, err_at, nib;
    logic [7:0] r;
    int         error_cnt, compares, cyc, rx_cnt, role;
    int         seed = 53;
    wire        mclk = sni_role ? swport_tx_clock_out : phyport_tx_clock;

    fpi_fifth_port dut_u (.*);
    fpi_link_partner far_u (.mac_role(mac_role), .sni_role(sni_role),
        .own_clk(swport_tx_clock_out), .link_on(link_on), .send(send), .base(base),
        .len(len), .err_at(err_at), .tx_clk(swport_tx_clock_in),
        .rx_clk(swport_rx_clock_in), .tx_en(swport_tx_enable),
        .tx_err(swport_tx_error), .tx_dat(swport_tx_data), .busy(p_busy));

    ////////////////////////////////////////////////////////////////////////////
    always #12.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (exp !== got) begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    function automatic logic [3:0] pat(input logic [3:0] b, input logic [3:0] i);
        return b + i * 4'h3;
    endfunction

    function automatic logic [3:0] oe_exp(input int rl);
        return (rl == 1) ? 4'h0 : (rl == 2) ? 4'he : 4'hf;
    endfunction

    task automatic tally_and_finish();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        if (rst_n && mac_rx_valid === 1'b1) begin
            check("rx_nibble", pat(base, 4'(rx_cnt)), mac_rx_nibble);
            check("rx_error", !sni_role && rx_cnt == err_at, mac_rx_error);
            rx_cnt++;
        end
    end

    task automatic fifth_port();
        int t0;
        nib = 4'($random(seed));
        r = 8'($random(seed));
        {phyport_tx_nibble, iphy_rx_nibble, phyport_tx_enable} = {nib, ~nib, 1'b1};
        {phyport_tx_error, mgmt_data_oe, mgmt_data_out, mdc} = r[6:3];
        {iphy_carrier, iphy_rx_error, iphy_rx_valid} = r[2:0];
        {mdio_in, iphy_collision, core_collision, core_carrier} = 4'($random(seed));
        {swport_collision_in, swport_carrier_sense_in} = {r[7], ~r[7]};
        t0 = 0;
        do begin
            step(1);
            t0++;
        end while (iphy_tx_valid !== 1'b1 && t0 < 40);
        check("phy_tx", {nib, r[6]}, {iphy_tx_nibble, iphy_tx_error});
        step(12);
        check("phy_rx", {~nib, r[5:0]}, {phyport_rx_nibble, mdio_oe, mdio_out,
            mgmt_clock, phyport_carrier_sense, phyport_rx_error, phyport_rx_valid});
        check("col_crs", {mdio_in, iphy_collision, core_collision, core_carrier, mac_role ?
            {swport_collision_in, swport_carrier_sense_in} : {core_collision, core_carrier}},
            {mgmt_data_in, phyport_collision, swport_collision_out, swport_carrier_sense_out,
            mac_collision, mac_carrier});
        {mdio_in, iphy_collision, core_collision, core_carrier} = 4'h0;
        {swport_collision_in, swport_carrier_sense_in} = 2'h0;
        phyport_tx_enable = 1'b0;
        @(posedge mclk);
        #1 t0 = cyc;
        @(posedge mclk);
        #1 check("link_clk", fpi_pkg::LINK_PERIOD_NS / fpi_pkg::CLK_PERIOD_NS, cyc - t0);
        check("clk_pins", 4'hf, {phyport_tx_clock, phyport_rx_clock, swport_tx_clock_out,
            swport_rx_clock_out});
    endtask

    task automatic rx_frame();
        int t;
        base   = 4'($random(seed));
        len    = 4'h7;
        err_at = 4'($random(seed)) % 4'h7;
        rx_cnt = 0;
        send = 1'b1;
        for (t = 0; t < 60 && p_busy !== 1'b1; t++) step(1);
        send = 1'b0;
        for (t = 0; t < 400 && p_busy !== 1'b0; t++) step(1);
        step(40);
        check("rx_count", len, rx_cnt);
    endtask

    task automatic tx_frames();
        int t, last, gap;
        gap = fpi_pkg::IPG_BIT_TIMES / (sni_role ? 1 : 4) * 8;
        for (int f = 0; f < 2; f++) begin
            mac_tx_valid = 1'b1;
            for (int k = 0; k < 3; k++) begin
                nib = 4'($random(seed));
                mac_tx_nibble = nib;
                t = 0;
                do begin
                    step(1);
                    t++;
                end while (mac_tx_take !== 1'b1 && t < 1500);
                if (f == 1 && k == 0) check("ipg", 1, cyc - last >= gap);
                check("tx_pins", {1'b1, sni_role ? {3'h0, nib[0]} : nib},
                    {swport_rx_valid, swport_rx_data});
                last = cyc;
            end
            mac_tx_valid = 1'b0;
            step(40);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {clk, rst_n, phyport_tx_enable, phyport_tx_error, mdc, mdio_in} = '0;
        {iphy_rx_valid, iphy_rx_error, iphy_collision, iphy_carrier} = '0;
        {mgmt_data_out, mgmt_data_oe, swport_collision_in, swport_carrier_sense_in} = '0;
        {mac_tx_valid, core_collision, core_carrier, mac_role, sni_role} = '0;
        {link_on, send, swport_role_strap, phyport_tx_nibble, iphy_rx_nibble} = '0;
        {mac_tx_nibble, base, len, err_at, error_cnt, compares, cyc} = '0;
        for (role = 0; role < 4; role++) begin
            swport_role_strap = 2'(role);
            {mac_role, sni_role, rst_n} = {role == 1, role == 2, 1'b0};
            step(10);
            check("reset_out", 3'h0, {mac_tx_take, swport_rx_valid, mac_rx_valid});
            rst_n = 1'b1;
            step(5);
            swport_role_strap = 2'((role + 1) % 3);
            link_on = 1'b1;
            step(5);
            check("pin_dirs", oe_exp(role), {swport_tx_clock_oe, swport_rx_clock_oe,
                swport_collision_oe, swport_carrier_sense_oe});
            fifth_port();
            rx_frame();
            tx_frames();
            link_on = 1'b0;
        end
        tally_and_finish();
    end

    initial begin
        #400_000;
        error_cnt++;
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
